// ==== include/dac_port_pkg.sv ====
// Package with port offsets, field layouts and reset values for the dual DAC port link.
package dac_port_pkg;

  // ************************************************************
  // Link widths
  // ************************************************************
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CODE_W = 12;
  localparam int unsigned HIGH_W = 4;

  // ************************************************************
  // Port offsets within the module block
  // ************************************************************
  localparam logic [2:0] OFS_CHAN0_LOW  = 3'h0;
  localparam logic [2:0] OFS_CHAN0_HIGH = 3'h1;
  localparam logic [2:0] OFS_CHAN1_LOW  = 3'h2;
  localparam logic [2:0] OFS_CHAN1_HIGH = 3'h3;
  // Only the low two offset bits select a port; bit 2 must be zero.
  localparam int unsigned OFS_TOP_BIT = 2;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [7:0]  BYTE_RESET = 8'h00;

  // ************************************************************
  // Host register map on Avalon-MM (word addresses)
  // ************************************************************
  localparam int unsigned AV_ADDR_W = 2;
  localparam logic [1:0] AV_CHAN0_CODE = 2'h0;
  localparam logic [1:0] AV_CHAN1_CODE = 2'h1;
  localparam logic [1:0] AV_CONTROL    = 2'h2;
  localparam logic [1:0] AV_STATUS     = 2'h3;
  localparam int unsigned CTRL_GO_BIT   = 0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// ==== include/dac_port_if.sv ====
// Interface carrying the 8-bit I/O write strobe between host and DAC module.
interface dac_port_if;
  logic       module_chip_select_first_n;
  logic [2:0] module_address_lines;
  logic [7:0] data;
  logic       write_n;

  modport host (
    output module_chip_select_first_n,
    output module_address_lines,
    output data,
    output write_n
  );

  modport device (
    input module_chip_select_first_n,
    input module_address_lines,
    input data,
    input write_n
  );
endinterface

// ==== hw/dac_port_device.sv ====
// Device end: double-buffered two-channel 12-bit code latches on a byte port bus.

// Notes on behaviour
// [R1] Decode three address lines plus first select.
// [R2] Offset zero loads first channel low byte.
// [R3] Offset one loads first channel bits 8-11.
// [R4] Offset two loads second channel low byte.
// [R5] Offset three loads second channel bits 8-11.
// [R6] Offset three updates both converter latches together.
// [R7] Converter latches hold until the update.
// [R8] Host uses only 8-bit I/O writes.
// [R9] No DMA handshake; programmed writes only.
// [R10] Host codes straight or offset binary.
// [R11] Host writes offsets zero to two first.
module dac_port_device (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Link to the host
  dac_port_if.device       link,
  // Converter codes
  output logic [11:0]      o_first_output_channel,
  output logic [11:0]      o_second_output_channel,
  output logic             o_update
);

  // ************************************************************
  // Write strobe detection
  // ************************************************************
  logic       wr_n_reg;
  logic       strobe;
  logic [2:0] ofs;

  // A write is taken once, on the falling edge of the write strobe, so a long
  // strobe from a slow host does not reload or re-update.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_n_reg <= 1'b1;
    end else begin
      wr_n_reg <= link.write_n;
    end
  end

  // Bit 2 must be low; only the first select is decoded, no DMA lines exist.
  assign ofs    = link.module_address_lines;
  assign strobe = !link.write_n && wr_n_reg && !link.module_chip_select_first_n
                  && !ofs[dac_port_pkg::OFS_TOP_BIT]; // see [R1] see [R9]

  // ************************************************************
  // Holding latches
  // ************************************************************
  logic [11:0] hold0_reg;
  logic [11:0] hold1_reg;

  // Low bytes use D0 as LSB; high writes keep D0..D3 and drop D4..D7.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hold0_reg <= dac_port_pkg::CODE_RESET;
      hold1_reg <= dac_port_pkg::CODE_RESET;
    end else if (strobe) begin
      case (ofs)
        dac_port_pkg::OFS_CHAN0_LOW: begin
          hold0_reg[7:0] <= link.data; // see [R2]
        end
        dac_port_pkg::OFS_CHAN0_HIGH: begin
          hold0_reg[11:8] <= link.data[3:0]; // see [R3]
        end
        dac_port_pkg::OFS_CHAN1_LOW: begin
          hold1_reg[7:0] <= link.data; // see [R4]
        end
        dac_port_pkg::OFS_CHAN1_HIGH: begin
          hold1_reg[11:8] <= link.data[3:0]; // see [R5]
        end
        default: begin
          hold0_reg <= hold0_reg;
        end
      endcase
    end
  end

  // ************************************************************
  // Converter latches
  // ************************************************************
  logic update_now;
  assign update_now = strobe && (ofs == dac_port_pkg::OFS_CHAN1_HIGH);

  // The final high byte bypasses its holding latch so the new value lands in the
  // same step as channel zero; otherwise both outputs stay put.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_first_output_channel  <= dac_port_pkg::CODE_RESET;
      o_second_output_channel <= dac_port_pkg::CODE_RESET;
      o_update                <= 1'b0;
    end else begin
      o_update <= update_now;
      if (update_now) begin
        o_first_output_channel  <= hold0_reg; // see [R6]
        o_second_output_channel <= {link.data[3:0], hold1_reg[7:0]}; // see [R6]
      end // see [R7]
    end
  end

endmodule

// ==== hw/dac_port_host.sv ====
// Host end: Avalon-MM registers turned into byte writes on the DAC port link.
//
// The implementer's own choice: the Avalon-MM register port.
module dac_port_host (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Avalon-MM slave
  input  wire logic [1:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Link to the device
  dac_port_if.host         link
);

  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [1:0] {IDLE_S, SETUP_S, STROBE_S, RELEASE_S} seq_type;
  seq_type     state_reg;
  logic [1:0]  idx_reg;
  logic [11:0] code0_reg;
  logic [11:0] code1_reg;
  logic        ack_reg;

  // Writes answer after one wait cycle; the go command stalls while busy.
  logic busy;
  logic take;
  assign busy = (state_reg != IDLE_S);
  assign take = (i_avs_read || i_avs_write) && !ack_reg;

  // Bus answer: waitrequest low for exactly one cycle per access.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_reg        <= 1'b0;
      o_avs_readdata <= dac_port_pkg::WORD_ZERO;
    end else begin
      ack_reg <= take && !(i_avs_write && i_avs_address == dac_port_pkg::AV_CONTROL
                 && busy);
      case (i_avs_address)
        dac_port_pkg::AV_CHAN0_CODE: o_avs_readdata <= {20'h0_0000, code0_reg};
        dac_port_pkg::AV_CHAN1_CODE: o_avs_readdata <= {20'h0_0000, code1_reg};
        dac_port_pkg::AV_STATUS:     o_avs_readdata <= {31'h0000_0000, busy};
        default:                     o_avs_readdata <= dac_port_pkg::WORD_ZERO;
      endcase
    end
  end
  assign o_avs_waitrequest = !ack_reg;

  // Code registers; straight or offset binary is software's concern.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      code0_reg <= dac_port_pkg::CODE_RESET;
      code1_reg <= dac_port_pkg::CODE_RESET;
    end else if (take && i_avs_write && !busy) begin
      if (i_avs_address == dac_port_pkg::AV_CHAN0_CODE) code0_reg <= i_avs_writedata[11:0];
      if (i_avs_address == dac_port_pkg::AV_CHAN1_CODE) code1_reg <= i_avs_writedata[11:0];
    end // see [R10]
  end

  // ************************************************************
  // Byte write sequencer
  // ************************************************************
  logic [7:0] byte_sel;
  always_comb begin
    case (idx_reg)
      2'd0:    byte_sel = code0_reg[7:0];
      2'd1:    byte_sel = {4'h0, code0_reg[11:8]};
      2'd2:    byte_sel = code1_reg[7:0];
      default: byte_sel = {4'h0, code1_reg[11:8]};
    endcase
  end

  // Four byte writes in offset order, the update byte last, each over three
  // cycles so the device sees a clean falling strobe.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg                       <= IDLE_S;
      idx_reg                         <= 2'd0;
      link.module_chip_select_first_n <= 1'b1;
      link.module_address_lines       <= dac_port_pkg::OFS_CHAN0_LOW;
      link.data                       <= dac_port_pkg::BYTE_RESET;
      link.write_n                    <= 1'b1;
    end else begin
      case (state_reg)
        IDLE_S: begin
          if (take && i_avs_write && i_avs_address == dac_port_pkg::AV_CONTROL
              && i_avs_writedata[dac_port_pkg::CTRL_GO_BIT]) begin
            idx_reg   <= 2'd0;
            state_reg <= SETUP_S;
          end
        end
        SETUP_S: begin
          link.module_chip_select_first_n <= 1'b0;
          link.module_address_lines       <= {1'b0, idx_reg}; // see [R11]
          link.data                       <= byte_sel; // see [R8]
          state_reg                       <= STROBE_S;
        end
        STROBE_S: begin
          link.write_n <= 1'b0;
          state_reg    <= RELEASE_S;
        end
        RELEASE_S: begin
          link.write_n                    <= 1'b1;
          link.module_chip_select_first_n <= 1'b1;
          idx_reg                         <= idx_reg + 2'd1;
          state_reg <= (idx_reg == dac_port_pkg::OFS_CHAN1_HIGH[1:0]) ? IDLE_S : SETUP_S;
        end
        default: begin
          state_reg <= IDLE_S;
        end
      endcase
    end
  end

endmodule

// ==== sim/dac_port_asserts.sv ====
// Checker for the byte port link between the host and device ends.
module dac_port_asserts (
  // Clock, reset, link and converter codes
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic        module_chip_select_first_n,
  input wire logic [2:0]  module_address_lines,
  input wire logic [7:0]  data,
  input wire logic        write_n,
  input wire logic [11:0] o_first_output_channel,
  input wire logic [11:0] o_second_output_channel,
  input wire logic        o_update
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Shadow of the holding latches
  // ********************
  logic        wp_reg;
  logic [1:0]  ofs_reg;
  logic [2:0]  since_reg;
  logic [11:0] h0_reg;
  logic [11:0] h1_reg;
  logic        take;
  logic        t3;
  // A byte is taken on the falling strobe edge only, as the device sees it.
  assign take = !write_n && wp_reg && !module_chip_select_first_n && !module_address_lines[2];
  assign t3 = take && module_address_lines == 3'h3;
  // The counter saturates so that a long idle cannot wrap into a false cause.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_reg <= 1'b1;
      ofs_reg <= 2'h3;
      since_reg <= 3'h7;
      h0_reg <= 12'h000;
      h1_reg <= 12'h000;
    end else begin
      wp_reg <= write_n;
      if (take) ofs_reg <= module_address_lines[1:0];
      since_reg <= t3 ? 3'h0 : (since_reg == 3'h7 ? since_reg : since_reg + 3'h1);
      if (take && module_address_lines == 3'h0) h0_reg[7:0] <= data;
      if (take && module_address_lines == 3'h1) h0_reg[11:8] <= data[3:0];
      if (take && module_address_lines == 3'h2) h1_reg[7:0] <= data;
      if (t3) h1_reg[11:8] <= data[3:0];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Checks on the link and the converter codes.
  AST_FIRST_CODE:
    assert property (t3 |-> ##[1:2] o_first_output_channel == h0_reg) else $error("bad first code");
  AST_SECOND_CODE:
    assert property (t3 |-> ##[1:2] o_second_output_channel == h1_reg) else $error("bad second code");
  AST_HOLD:
    assert property (($changed(o_first_output_channel) || $changed(o_second_output_channel))
      |-> since_reg <= 3'h2) else $error("codes moved without update");
  AST_UPDATE_CAUSE:
    assert property (o_update |-> since_reg <= 3'h2) else $error("update without last byte");
  AST_UPDATE_SOON:
    assert property (t3 |-> ##[1:3] o_update) else $error("update missing");
  AST_PULSE:
    assert property (o_update |=> !o_update) else $error("update longer than one cycle");
  AST_SELECT:
    assert property (!write_n |-> !module_chip_select_first_n) else $error("strobe unselected");
  // The strobe is low for a single cycle, so steadiness is held over the whole select.
  AST_STEADY:
    assert property (!module_chip_select_first_n && !$past(module_chip_select_first_n)
      |-> $stable(data) && $stable(module_address_lines))
      else $error("link moved in select");
  AST_ORDER:
    assert property (take |-> module_address_lines[1:0] == ofs_reg + 2'h1) else $error("bad order");
endmodule

// ==== sim/tb.sv ====
// Testbench joining host and device ends over the byte port link.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [1:0]  adr = 2'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] q;
  logic [31:0] rdata;
  logic        wq;
  logic [11:0] o0;
  logic [11:0] o1;
  logic        upd;
  logic        wp = 1'b1;
  logic [10:0] seen[$];
  int          miscompares = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          updates = 0;
  dac_port_if dac_port_if_inst ();
  dac_port_host dac_port_host_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(q),
    .o_avs_waitrequest(wq), .link(dac_port_if_inst.host));
  dac_port_device dac_port_device_inst (.i_clk(i_clk), .i_nrst(i_nrst),
    .link(dac_port_if_inst.device), .o_first_output_channel(o0),
    .o_second_output_channel(o1), .o_update(upd));
  dac_port_asserts dac_port_asserts_inst (.i_clk(i_clk), .i_nrst(i_nrst),
    .module_chip_select_first_n(dac_port_if_inst.module_chip_select_first_n),
    .module_address_lines(dac_port_if_inst.module_address_lines),
    .data(dac_port_if_inst.data), .write_n(dac_port_if_inst.write_n),
    .o_first_output_channel(o0), .o_second_output_channel(o1), .o_update(upd));
  always #20 i_clk = ~i_clk;
  // Log each strobed byte, count update pulses and cut a hang short.
  always @(posedge i_clk) begin
    cyc++;
    if (i_nrst && !dac_port_if_inst.write_n && wp && !dac_port_if_inst.module_chip_select_first_n)
      seen.push_back({dac_port_if_inst.module_address_lines, dac_port_if_inst.data});
    if (upd) updates++;
    wp = dac_port_if_inst.write_n;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // The request rises just after a rising edge and stands until waitrequest is seen low
  // at a rising edge; read data is taken there. A hang is left to the cycle ceiling.
  task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do begin
      @(posedge i_clk);
    end while (wq !== 1'b0);
    rdata = q;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge i_clk);
  endtask
  // Expected link byte j: offset on top, high bytes compared on D3 to D0 only.
  function automatic logic [10:0] exp_b(input logic [11:0] c0, c1, input int j);
    logic [11:0] c;
    c = j > 1 ? c1 : c0;
    return {3'(j), j % 2 ? {4'h0, c[11:8]} : c[7:0]};
  endfunction
  initial begin
    logic [11:0] c0, c1, p0, p1;
    int k, m;
    void'($urandom(32'h65d0));
    p0 = 12'h000;
    p1 = 12'h000;
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    for (k = 0; k < 12; k++) begin
      c0 = k == 0 ? 12'hfff : (k == 1 ? 12'h800 : 12'($urandom));
      c1 = k == 0 ? 12'h000 : (k == 1 ? 12'hfff : 12'($urandom));
      av(1'b1, 2'h0, {20'h0_0000, c0});
      av(1'b1, 2'h1, {20'h0_0000, c1});
      chk("held first", p0, o0);
      chk("held second", p1, o1);
      seen.delete();
      av(1'b1, 2'h2, 32'h0000_0001);
      if (k % 2 == 1) av(1'b1, 2'h0, 32'h0000_0abc);
      m = 0;
      do begin
        av(1'b0, 2'h3, 32'h0000_0000);
        m++;
      end while (rdata[0] !== 1'b0 && m < 20);
      chk("first code", c0, o0);
      chk("second code", c1, o1);
      chk("byte count", 4, seen.size());
      for (m = 0; m < 4; m++)
        chk("link byte", exp_b(c0, c1, m), seen[m] & (m % 2 ? 11'h70f : 11'h7ff));
      chk("update pulses", k + 1, updates);
      av(1'b0, 2'h0, 32'h0000_0000);
      chk("kept code", c0, rdata[11:0]);
      av(1'b0, 2'h1, 32'h0000_0000);
      chk("kept second", c1, rdata[11:0]);
      p0 = c0;
      p1 = c1;
    end
    test_done();
  end
endmodule
